// file: pkg/gdm_pkg.sv
/*
 * Constants and types for the general-purpose pin and digital microphone block.
 * Assumes a single core clock of 100 MHz and an 8-bit register port.
 */
package gdm_pkg;
    // Register port widths.
    localparam int REG_AW = 8;
    localparam int REG_DW = 8;

    // Register offsets on the register port.
    localparam logic [7:0] REG_HEADSET = 8'h0D;
    localparam logic [7:0] REG_MICCFG = 8'h19;
    localparam logic [7:0] REG_SCCTL = 8'h26;
    localparam logic [7:0] REG_SCFLAG = 8'h5F;
    localparam logic [7:0] REG_DMIC = 8'h6B;
    localparam logic [7:0] REG_PIN1 = 8'h70;
    localparam logic [7:0] REG_PIN2 = 8'h71;
    localparam logic [7:0] REG_ROUTE = 8'h72;
    localparam logic [7:0] REG_STATUS = 8'h73;
    localparam logic [7:0] REG_LEVEL = 8'h74;
    localparam logic [7:0] REG_DRVPWR = 8'h75;

    // Values after reset.
    localparam logic [7:0] REG_RST = 8'h00;
    localparam logic [7:0] SCCTL_RST = 8'h04;

    // Field positions.
    localparam int DMIC_LSB = 4;
    localparam int SC_EN_BIT = 2;
    localparam int SC_APD_BIT = 1;
    localparam int PIN_MODE_LSB = 0;
    localparam int PIN_LEVEL_BIT = 2;
    localparam int PIN_TRAIN_BIT = 3;

    // Interrupt source positions in the status register.
    localparam int NUM_IRQ = 4;
    localparam int IRQ_JACK = 0;
    localparam int IRQ_BUTTON = 1;
    localparam int IRQ_SHORT = 2;
    localparam int IRQ_AGC = 3;

    // Oversampling ratio codes and clock toggle limits in 256x sample-rate ticks.
    localparam logic [1:0] OSR_OFF = 2'h0;
    localparam logic [1:0] OSR_128 = 2'h1;
    localparam logic [1:0] OSR_64 = 2'h2;
    localparam logic [1:0] OSR_32 = 2'h3;
    localparam logic [1:0] DIV_128 = 2'h0;
    localparam logic [1:0] DIV_64 = 2'h1;
    localparam logic [1:0] DIV_32 = 2'h3;

    // Microphone latch edge codes.
    localparam logic [1:0] EDGE_BOTH = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;

    // Interrupt pulse timing.
    localparam int CLK_PERIOD_NS = 10;
    localparam int IRQ_PULSE_NS = 100;
    localparam int IRQ_TRAIN_NS = 2000;
    localparam logic [7:0] IRQ_PULSE_CYC =
        8'((IRQ_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] IRQ_TRAIN_CYC = 8'(IRQ_TRAIN_NS / CLK_PERIOD_NS);

    // Function selected for a general-purpose pin.
    typedef enum logic [1:0] {PIN_IN, PIN_OUT, PIN_CLK, PIN_IRQ} gdm_pin_mode_t;
endpackage

// file: pkg/gdm_dmic_if.sv
/*
 * Signals between the pin block and its digital microphone port.
 * Assumes both ends run on the same core clock.
 */
`timescale 1ns/1ps
interface gdm_dmic_if;
    logic ce;
    logic os_tick;
    logic [1:0] osr_sel;
    logic [1:0] edge_sel;
    logic data_sync;
    logic clk_out;
    logic left_bit;
    logic left_vld;
    logic right_bit;
    logic right_vld;

    modport ctl (output ce, os_tick, osr_sel, edge_sel, data_sync,
                 input clk_out, left_bit, left_vld, right_bit, right_vld);
    modport port (input ce, os_tick, osr_sel, edge_sel, data_sync,
                  output clk_out, left_bit, left_vld, right_bit, right_vld);
endinterface

// file: verilog/gdm_dmic.sv
/*
 * Digital microphone port: makes the oversampling clock and latches the bitstream.
 * Assumes the data input is already synchronised to the core clock.
 */
`timescale 1ns/1ps
module gdm_dmic
(
    input wire logic sys_clk,
    input wire logic rst_n,
    gdm_dmic_if.port dm
);
    import gdm_pkg::*;

    logic [1:0] cnt_r, cnt_nxt, lim;
    logic clk_r, clk_nxt;
    logic lb_r, lb_nxt, lv_r, lv_nxt, rb_r, rb_nxt, rv_r, rv_nxt;
    logic on, tgl, rise_ok, fall_ok;

    // Divides the 256x tick down to the programmed oversampling clock.
    always_comb
    begin
        on = (dm.osr_sel != OSR_OFF);
        lim = (dm.osr_sel == OSR_128) ? DIV_128 : (dm.osr_sel == OSR_64) ? DIV_64 : DIV_32;
        tgl = on && dm.os_tick && (cnt_r == lim);
        rise_ok = (dm.edge_sel != EDGE_FALL);
        fall_ok = (dm.edge_sel != EDGE_RISE);
        cnt_nxt = cnt_r;
        clk_nxt = clk_r;
        lb_nxt = lb_r;
        rb_nxt = rb_r;
        lv_nxt = 1'b0;
        rv_nxt = 1'b0;
        if (!on)
        begin
            cnt_nxt = 2'h0;
            clk_nxt = 1'b0;
        end
        else if (dm.os_tick)
        begin
            cnt_nxt = tgl ? 2'h0 : cnt_r + 2'h1;
        end
        if (tgl)
        begin
            clk_nxt = !clk_r;
            // Left on the rising edge, right on the falling edge.
            if (!clk_r && rise_ok)
            begin
                lb_nxt = dm.data_sync;
                lv_nxt = 1'b1;
            end
            if (clk_r && fall_ok)
            begin
                rb_nxt = dm.data_sync;
                rv_nxt = 1'b1;
            end
        end
    end

    // Registers the divider and capture state; all hold while the enable is low.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            cnt_r <= 2'h0;
            clk_r <= 1'b0;
            lb_r <= 1'b0;
            lv_r <= 1'b0;
            rb_r <= 1'b0;
            rv_r <= 1'b0;
        end
        else if (dm.ce)
        begin
            cnt_r <= cnt_nxt;
            clk_r <= clk_nxt;
            lb_r <= lb_nxt;
            lv_r <= lv_nxt;
            rb_r <= rb_nxt;
            rv_r <= rv_nxt;
        end
    end

    assign dm.clk_out = clk_r;
    assign dm.left_bit = lb_r;
    assign dm.left_vld = lv_r && dm.ce;
    assign dm.right_bit = rb_r;
    assign dm.right_vld = rv_r && dm.ce;

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_left_on_rise: assert property (lv_r |-> clk_r && $past(!clk_r))
        else $error("Left capture not on a rising clock edge.");
    a_right_on_fall: assert property (rv_r |-> !clk_r && $past(clk_r))
        else $error("Right capture not on a falling clock edge.");
    a_edge_rise_only: assert property (dm.edge_sel == EDGE_RISE &&
        $past(dm.edge_sel) == EDGE_RISE |-> !rv_r)
        else $error("Right capture while latching on rising edge only.");
    c_stereo_capture: cover property (lv_r ##[1:16] rv_r);
endmodule

// file: verilog/gdm_top.sv
/*
 * General-purpose pins, interrupt routing, short-circuit flag and digital microphone.
 * Assumes event inputs and short sensing are already on the core clock; pin inputs are not.
 */
// Overview of operation
// - Input pin level readable by register read.
// - Output pin drives programmed high or low.
// - Pin may output internal clock or interrupt.
// - Jack, button, short and AGC noise events.
// - Each event routable alone or ORed together.
// - Status register shows which event fired.
// - Single pulse, or train until status read.
// - Microphone bits feed the decimation filter.
// - Oversampling clock 128, 64 or 32 times.
// - First pin clock out, second pin data.
// - Left on rising, right on falling edge.
// - Latch on rising, falling or both edges.
// - Microphone mode blocks analog ADC conversion.
// - Setup in bits 5-4 of 107 and 25.
// - Readable short-circuit protection flag in 95.
// - Auto power-down holds until power cycled.
// - Detected headset type readable in 13.
`timescale 1ns/1ps
module gdm_top
#(
    parameter int NUM_DRV = 4
)
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [gdm_pkg::REG_AW-1:0] reg_addr,
    input wire logic [gdm_pkg::REG_DW-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [gdm_pkg::REG_DW-1:0] reg_rdata,
    input wire logic first_general_pin_i,
    output logic first_general_pin_o,
    output logic first_general_pin_oe,
    input wire logic second_general_pin_i,
    output logic second_general_pin_o,
    output logic second_general_pin_oe,
    input wire logic int_clk_level,
    input wire logic adc_sample_rate_x256_tick,
    input wire logic jack_done,
    input wire logic [1:0] headset_type,
    input wire logic button_evt,
    input wire logic agc_noise_evt,
    input wire logic [NUM_DRV-1:0] short_sense,
    output logic [NUM_DRV-1:0] drv_power_on,
    output logic adc_analog_off,
    output logic dmic_left_bit,
    output logic dmic_left_vld,
    output logic dmic_right_bit,
    output logic dmic_right_vld
);
    import gdm_pkg::*;

    gdm_dmic_if dm ();

    logic [1:0] pin_meta_r, pin_meta_nxt, pin_sync_r, pin_sync_nxt;
    logic [7:0] mic_r, mic_nxt, scctl_r, scctl_nxt, dmic_r, dmic_nxt;
    logic [7:0] route_r, route_nxt, drvpwr_r, drvpwr_nxt, rd_r, rd_nxt;
    logic [7:0] pin_cfg_r [0:1];
    logic [7:0] pin_cfg_nxt [0:1];
    logic [1:0] headset_r, headset_nxt;
    logic [NUM_IRQ-1:0] status_r, status_nxt, evt_vec;
    logic [NUM_DRV-1:0] sc_lat_r, sc_lat_nxt, sc_prev_r, sc_prev_nxt, sc_flag;
    logic wr_hit, rd_hit, dmic_on, sc_evt;
    logic [1:0] irq, pin_o_r, pin_o_nxt, pin_oe_r, pin_oe_nxt;

    // Two-stage synchronisers for both pins; only the second stage is read.
    always_comb
    begin
        pin_meta_nxt = ce ? {second_general_pin_i, first_general_pin_i} : pin_meta_r;
        pin_sync_nxt = ce ? pin_meta_r : pin_sync_r;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            pin_meta_r <= 2'h0;
            pin_sync_r <= 2'h0;
        end
        else
        begin
            pin_meta_r <= pin_meta_nxt;
            pin_sync_r <= pin_sync_nxt;
        end
    end

    // Short-circuit flags and automatic driver power-down.
    always_comb
    begin
        sc_lat_nxt = sc_lat_r;
        for (int i = 0; i < NUM_DRV; i++)
        begin
            if (!drvpwr_r[i])
                sc_lat_nxt[i] = 1'b0;
            else if (scctl_r[SC_EN_BIT] && scctl_r[SC_APD_BIT] && short_sense[i])
                sc_lat_nxt[i] = 1'b1;
        end
        sc_flag = sc_lat_r | (short_sense & drvpwr_r[NUM_DRV-1:0] & {NUM_DRV{scctl_r[SC_EN_BIT]}});
        sc_prev_nxt = sc_flag;
        sc_evt = |(sc_flag & ~sc_prev_r);
        if (!ce)
        begin
            sc_lat_nxt = sc_lat_r;
            sc_prev_nxt = sc_prev_r;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            sc_lat_r <= '0;
            sc_prev_r <= '0;
        end
        else
        begin
            sc_lat_r <= sc_lat_nxt;
            sc_prev_r <= sc_prev_nxt;
        end
    end

    assign drv_power_on = drvpwr_r[NUM_DRV-1:0] & ~sc_lat_r;

    // Register file, sticky interrupt status and read data.
    always_comb
    begin
        wr_hit = ce && reg_wr;
        rd_hit = ce && reg_rd;
        evt_vec = '0;
        evt_vec[IRQ_JACK] = jack_done;
        evt_vec[IRQ_BUTTON] = button_evt;
        evt_vec[IRQ_SHORT] = sc_evt;
        evt_vec[IRQ_AGC] = agc_noise_evt;
        mic_nxt = (wr_hit && reg_addr == REG_MICCFG) ? reg_wdata : mic_r;
        scctl_nxt = (wr_hit && reg_addr == REG_SCCTL) ? reg_wdata : scctl_r;
        dmic_nxt = (wr_hit && reg_addr == REG_DMIC) ? reg_wdata : dmic_r;
        pin_cfg_nxt[0] = (wr_hit && reg_addr == REG_PIN1) ? reg_wdata : pin_cfg_r[0];
        pin_cfg_nxt[1] = (wr_hit && reg_addr == REG_PIN2) ? reg_wdata : pin_cfg_r[1];
        route_nxt = (wr_hit && reg_addr == REG_ROUTE) ? reg_wdata : route_r;
        drvpwr_nxt = (wr_hit && reg_addr == REG_DRVPWR) ? reg_wdata : drvpwr_r;
        headset_nxt = (ce && jack_done) ? headset_type : headset_r;
        // Reading the status clears it; an event in the same cycle still sets.
        status_nxt = status_r;
        if (rd_hit && reg_addr == REG_STATUS)
            status_nxt = '0;
        if (ce)
            status_nxt = status_nxt | evt_vec;
        rd_nxt = 8'h00;
        if (rd_hit)
        begin
            case (reg_addr)
                REG_HEADSET: rd_nxt = {6'h00, headset_r};
                REG_MICCFG: rd_nxt = mic_r;
                REG_SCCTL: rd_nxt = scctl_r;
                REG_SCFLAG: rd_nxt[NUM_DRV-1:0] = sc_flag;
                REG_DMIC: rd_nxt = dmic_r;
                REG_PIN1: rd_nxt = pin_cfg_r[0];
                REG_PIN2: rd_nxt = pin_cfg_r[1];
                REG_ROUTE: rd_nxt = route_r;
                REG_STATUS: rd_nxt = {4'h0, status_r};
                REG_LEVEL: rd_nxt = {6'h00, pin_sync_r};
                REG_DRVPWR: rd_nxt = drvpwr_r;
                default: rd_nxt = 8'h00;
            endcase
        end
        else if (!ce)
        begin
            rd_nxt = rd_r;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            mic_r <= REG_RST;
            scctl_r <= SCCTL_RST;
            dmic_r <= REG_RST;
            pin_cfg_r[0] <= REG_RST;
            pin_cfg_r[1] <= REG_RST;
            route_r <= REG_RST;
            drvpwr_r <= REG_RST;
            headset_r <= 2'h0;
            status_r <= '0;
            rd_r <= REG_RST;
        end
        else
        begin
            mic_r <= mic_nxt;
            scctl_r <= scctl_nxt;
            dmic_r <= dmic_nxt;
            pin_cfg_r[0] <= pin_cfg_nxt[0];
            pin_cfg_r[1] <= pin_cfg_nxt[1];
            route_r <= route_nxt;
            drvpwr_r <= drvpwr_nxt;
            headset_r <= headset_nxt;
            status_r <= status_nxt;
            rd_r <= rd_nxt;
        end
    end

    assign reg_rdata = rd_r;

    // Digital microphone port; analog conversion is blocked while it runs.
    assign dmic_on = (dmic_r[DMIC_LSB +: 2] != OSR_OFF);
    assign adc_analog_off = dmic_on;
    assign dm.ce = ce;
    assign dm.os_tick = adc_sample_rate_x256_tick;
    assign dm.osr_sel = dmic_r[DMIC_LSB +: 2];
    assign dm.edge_sel = mic_r[DMIC_LSB +: 2];
    assign dm.data_sync = pin_sync_r[1];
    assign dmic_left_bit = dm.left_bit;
    assign dmic_left_vld = dm.left_vld;
    assign dmic_right_bit = dm.right_bit;
    assign dmic_right_vld = dm.right_vld;

    gdm_dmic u_dmic
    (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .dm(dm.port)
    );

    // Per-pin interrupt pulse generator and pin driver.
    for (genvar p = 0; p < 2; p++)
    begin : g_pin
        logic [7:0] hi_r, hi_nxt, per_r, per_nxt;
        logic [3:0] mask;
        logic pend, new_evt, train;
        gdm_pin_mode_t mode;

        always_comb
        begin
            mask = route_r[4*p +: 4];
            pend = |(status_r & mask);
            new_evt = |(evt_vec & mask);
            train = pin_cfg_r[p][PIN_TRAIN_BIT];
            mode = gdm_pin_mode_t'(pin_cfg_r[p][PIN_MODE_LSB +: 2]);
            hi_nxt = (hi_r != 8'h00) ? hi_r - 8'h01 : 8'h00;
            per_nxt = (per_r != 8'h00) ? per_r - 8'h01 : 8'h00;
            if (new_evt)
            begin
                hi_nxt = IRQ_PULSE_CYC;
                per_nxt = IRQ_TRAIN_CYC;
            end
            else if (train && pend && per_r == 8'h00)
            begin
                hi_nxt = IRQ_PULSE_CYC;
                per_nxt = IRQ_TRAIN_CYC;
            end
            if (!ce)
            begin
                hi_nxt = hi_r;
                per_nxt = per_r;
            end
            pin_o_nxt[p] = 1'b0;
            pin_oe_nxt[p] = 1'b0;
            if (dmic_on)
            begin
                pin_oe_nxt[p] = (p == 0);
                pin_o_nxt[p] = (p == 0) && dm.clk_out;
            end
            else
            begin
                case (mode)
                    PIN_IN: pin_oe_nxt[p] = 1'b0;
                    PIN_OUT:
                    begin
                        pin_oe_nxt[p] = 1'b1;
                        pin_o_nxt[p] = pin_cfg_r[p][PIN_LEVEL_BIT];
                    end
                    PIN_CLK:
                    begin
                        pin_oe_nxt[p] = 1'b1;
                        pin_o_nxt[p] = int_clk_level;
                    end
                    PIN_IRQ:
                    begin
                        pin_oe_nxt[p] = 1'b1;
                        pin_o_nxt[p] = (hi_r != 8'h00);
                    end
                    default: pin_oe_nxt[p] = 1'b0;
                endcase
            end
            if (!ce)
            begin
                pin_o_nxt[p] = pin_o_r[p];
                pin_oe_nxt[p] = pin_oe_r[p];
            end
        end

        always_ff @(posedge sys_clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                hi_r <= 8'h00;
                per_r <= 8'h00;
                pin_o_r[p] <= 1'b0;
                pin_oe_r[p] <= 1'b0;
            end
            else
            begin
                hi_r <= hi_nxt;
                per_r <= per_nxt;
                pin_o_r[p] <= pin_o_nxt[p];
                pin_oe_r[p] <= pin_oe_nxt[p];
            end
        end

        assign irq[p] = (hi_r != 8'h00);
    end

    assign first_general_pin_o = pin_o_r[0];
    assign first_general_pin_oe = pin_oe_r[0];
    assign second_general_pin_o = pin_o_r[1];
    assign second_general_pin_oe = pin_oe_r[1];

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    a_level_read: assert property (rd_hit && reg_addr == REG_LEVEL |=> reg_rdata == {6'h00, $past(pin_sync_r)})
        else $error("Pin level read does not match synchronised level.");
    a_pin_drive: assert property (ce && !dmic_on && pin_cfg_r[0][1:0] == 2'h1 |=> first_general_pin_oe && first_general_pin_o == $past(pin_cfg_r[0][PIN_LEVEL_BIT]))
        else $error("Output pin not driving programmed level.");
    a_clk_out: assert property (ce && !dmic_on && pin_cfg_r[1][1:0] == 2'h2 |=> second_general_pin_o == $past(int_clk_level))
        else $error("Clock mode pin does not follow internal clock.");
    a_event_sticky: assert property (ce && button_evt |=> status_r[IRQ_BUTTON])
        else $error("Button event lost from status.");
    a_route_pulse: assert property (ce && g_pin[0].new_evt ##1 ce[*2] |-> irq[0] [*2])
        else $error("Routed event did not raise a pulse.");
    a_train_repeat: assert property (ce && g_pin[1].train && g_pin[1].pend && g_pin[1].per_r == 8'h00 |=> irq[1])
        else $error("Pulse train did not repeat while pending.");
    a_dmic_pins: assert property (ce && dmic_on |=> first_general_pin_oe && !second_general_pin_oe)
        else $error("Microphone mode pin directions wrong.");
    a_analog_off: assert property (wr_hit && reg_addr == REG_DMIC && reg_wdata[5:4] != 2'h0 |=> adc_analog_off)
        else $error("Analog conversion not blocked in microphone mode.");
    a_sc_hold: assert property (sc_lat_r[0] && drvpwr_r[0] |=>
        sc_lat_r[0] && !drv_power_on[0])
        else $error("Latched short-circuit driver released before a power cycle.");
    a_headset: assert property (ce && jack_done |=> headset_r == $past(headset_type))
        else $error("Headset type not captured on detection.");
    a_sync_delay: assert property (ce [*3] |-> dm.data_sync == $past(second_general_pin_i, 2))
        else $error("Microphone data synchroniser depth wrong.");
    c_train: cover property (irq[1] ##1 !irq[1] ##[1:300] irq[1]);
    c_apd: cover property ($rose(sc_lat_r[0]));
    c_dmic_run: cover property (dmic_on ##[1:64] dmic_left_vld);
endmodule

// file: test/gdm_mic_model.sv
/*
 * Stereo digital microphone model that drives the data line of the second pin.
 * Assumes its clock is the oversampling clock driven out on the first pin.
 */
`timescale 1ns/1ps
module gdm_mic_model
(
    input wire logic mic_clk,
    input wire logic left_val,
    input wire logic right_val,
    output logic mic_data
);
    // Left data settles after the falling edge, ready for the rising capture.
    initial mic_data = 1'b0;
    always @(negedge mic_clk) mic_data <= left_val;
    // Right data settles after the rising edge, ready for the falling capture.
    always @(posedge mic_clk) mic_data <= right_val;
endmodule

// file: test/testbench.sv
/*
 * Self-checking bench for the pin, interrupt, short flag and microphone block.
 * Assumes read data stand only in the cycle after the read strobe.
 */
`timescale 1ns/1ps
module testbench;
    import gdm_pkg::*;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic p1_drv = 1'b0, p2_drv = 1'b0, use_mic = 1'b0, lv = 1'b0, rv = 1'b0;
    logic clk_lvl = 1'b0, clr = 1'b0, irq_q = 1'b0, ce_in = 1'b1, tick = 1'b0;
    logic mic_data, p1_o, p1_oe, p2_o, p2_oe, ana_off, l_bit, l_vld, r_bit, r_vld, irq;
    logic [3:0] ev = 4'h0;
    logic [3:0] short_in = 4'h0;
    logic [3:0] drv_on;
    logic [1:0] hs_type = 2'h2;
    logic [7:0] ra [12] = '{REG_HEADSET, REG_MICCFG, REG_SCCTL, REG_SCFLAG, REG_DMIC,
        REG_PIN1, REG_PIN2, REG_ROUTE, REG_STATUS, REG_LEVEL, REG_DRVPWR, 8'h10};
    int n_fail = 0;
    int n_tests = 0;
    int n_rise, n_high, n_lok, n_rok;

    // Clock source at 100 MHz.
    always #5 sys_clk = ~sys_clk;

    // Tick at 256 times the sample rate, on every other core cycle.
    always @(posedge sys_clk) tick <= ~tick;

    gdm_top u_dut
    (
        .sys_clk(sys_clk), .rst_n(rst_n), .ce(ce_in), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .first_general_pin_i(p1_drv), .first_general_pin_o(p1_o),
        .first_general_pin_oe(p1_oe), .second_general_pin_i(use_mic ? mic_data : p2_drv),
        .second_general_pin_o(p2_o), .second_general_pin_oe(p2_oe),
        .int_clk_level(clk_lvl), .adc_sample_rate_x256_tick(tick), .jack_done(ev[0]),
        .headset_type(hs_type), .button_evt(ev[1]), .agc_noise_evt(ev[3]),
        .short_sense(short_in), .drv_power_on(drv_on), .adc_analog_off(ana_off),
        .dmic_left_bit(l_bit), .dmic_left_vld(l_vld), .dmic_right_bit(r_bit),
        .dmic_right_vld(r_vld)
    );

    gdm_mic_model u_mic
    (
        .mic_clk(p1_o & p1_oe), .left_val(lv), .right_val(rv), .mic_data(mic_data)
    );

    // Counts driven pulses on both pins and scores every microphone capture.
    assign irq = (p1_o & p1_oe) | (p2_o & p2_oe);
    always @(posedge sys_clk)
    begin
        irq_q <= irq;
        if (clr)
        begin
            n_rise = 0;
            n_high = 0;
            n_lok = 0;
            n_rok = 0;
        end
        else
        begin
            n_rise += int'(irq && !irq_q);
            n_high += int'(irq);
            n_lok += l_vld ? ((l_bit === lv) ? 1 : -100) : 0;
            n_rok += r_vld ? ((r_bit === rv) ? 1 : -100) : 0;
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        check(reg_rdata, e);
    endtask

    task automatic run(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    task automatic clear();
        @(posedge sys_clk);
        clr <= 1'b1;
        @(posedge sys_clk);
        clr <= 0;
    endtask

    // Raises one event for a cycle, or a lasting short, and restarts the counters.
    task automatic fire(input int k);
        @(posedge sys_clk);
        if (k == IRQ_SHORT)
            short_in <= 4'h1;
        else
            ev[k] <= 1'b1;
        clr <= 1'b1;
        @(posedge sys_clk);
        ev <= 4'h0;
        clr <= 1'b0;
    endtask

    task automatic done(input string s);
        $display("Test %s finished, %0d mismatches so far.", s, n_fail);
    endtask

    task automatic wrap_up();
        $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // Hang guard, well beyond the few thousand cycles the tests need.
    initial
    begin
        #300us;
        n_fail++;
        wrap_up();
    end

    // Main sequence of tests.
    initial
    begin
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        foreach (ra[i]) rd(ra[i], (ra[i] == REG_SCCTL) ? SCCTL_RST : REG_RST);
        wr(REG_HEADSET, 8'h03);
        rd(REG_HEADSET, 8'h00);
        done("reset");
        for (int i = 0; i < 4; i++)
        begin
            p1_drv <= i[0];
            p2_drv <= i[1];
            run(3);
            rd(REG_LEVEL, 8'(i));
        end
        for (int i = 0; i < 2; i++)
        begin
            wr(REG_PIN1, 8'h01 | 8'(i << PIN_LEVEL_BIT));
            wr(REG_PIN2, 8'h01 | 8'(i << PIN_LEVEL_BIT));
            run(2);
            check({p1_o, p1_oe, p2_o, p2_oe}, {i[0], 1'b1, i[0], 1'b1});
        end
        rd(REG_PIN1, 8'h05);
        for (int i = 0; i < 2; i++)
        begin
            clk_lvl <= i[0];
            wr(REG_PIN1, 8'h02);
            wr(REG_PIN2, 8'h02);
            run(3);
            check({p1_o, p1_oe, p2_o, p2_oe}, {i[0], 1'b1, i[0], 1'b1});
        end
        // With the enable low the clock-mode pin must hold its last level.
        ce_in <= 1'b0;
        clk_lvl <= 1'b0;
        run(3);
        check(p1_o, 1'b1);
        ce_in <= 1'b1;
        run(3);
        check(p1_o, 1'b0);
        done("pins");
        wr(REG_DRVPWR, 8'h01);
        wr(REG_ROUTE, 8'h0F);
        wr(REG_PIN1, 8'h03);
        wr(REG_PIN2, 8'h00);
        for (int k = 0; k < NUM_IRQ; k++)
        begin
            fire(k);
            run(300);
            check(n_rise, 1);
            check(n_high, 32'(IRQ_PULSE_CYC));
            if (k == IRQ_SHORT) rd(REG_SCFLAG, 8'h01);
            short_in <= 4'h0;
            rd(REG_STATUS, 8'(1 << k));
            rd(REG_STATUS, 8'h00);
        end
        rd(REG_SCFLAG, 8'h00);
        rd(REG_HEADSET, {6'h0, hs_type});
        wr(REG_ROUTE, 8'h20);
        wr(REG_PIN2, 8'h03);
        fire(IRQ_AGC);
        run(300);
        check(n_rise, 0);
        fire(IRQ_BUTTON);
        run(300);
        check(n_rise, 1);
        rd(REG_STATUS, 8'h0A);
        wr(REG_PIN2, 8'h0B);
        fire(IRQ_BUTTON);
        run(450);
        check(n_rise, 3);
        rd(REG_STATUS, 8'h02);
        clear();
        run(450);
        check(n_rise, 0);
        done("interrupts");
        wr(REG_SCCTL, 8'h06);
        short_in <= 4'h1;
        run(5);
        check(drv_on, 4'h0);
        short_in <= 4'h0;
        rd(REG_SCFLAG, 8'h01);
        wr(REG_DRVPWR, 8'h00);
        wr(REG_DRVPWR, 8'h01);
        rd(REG_SCFLAG, 8'h00);
        check(drv_on, 4'h1);
        rd(REG_STATUS, 8'h04);
        done("short circuit");
        for (int c = 1; c < 4; c++)
        begin
            wr(REG_DMIC, 8'(c << DMIC_LSB));
            run(8);
            clear();
            run(64);
            check(n_rise, 32 >> c);
            check({p1_oe, p2_oe, ana_off}, 3'b101);
        end
        use_mic <= 1'b1;
        for (int e = 0; e < 4; e++)
        begin
            lv <= e[0];
            rv <= !e[0];
            wr(REG_MICCFG, 8'(e << 4));
            run(24);
            clear();
            run(80);
            check(n_lok, (e == 2) ? 0 : 5);
            check(n_rok, (e == 1) ? 0 : 5);
        end
        wr(REG_DMIC, 8'h00);
        run(3);
        check(ana_off, 1'b0);
        done("microphone");
        wrap_up();
    end
endmodule
